// *** include/ssc_pkg.sv ***
// shared constants and carriers for the clocked serial channel with operation clock select
package ssc_pkg;

   // ****************************************************************
   // bus, field and counter widths
   // ****************************************************************
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 16;
   localparam int WORD_BITS = 8;
   localparam int DIV_W     = 7;
   localparam int PCNT_W    = 11;
   localparam int IRQ_W     = 3;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_DATA     = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_MODE     = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_PRESC    = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STAT     = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h5;

   // ****************************************************************
   // field positions and prescaler field width
   // ****************************************************************
   localparam int DIV_MSB         = 15;
   localparam int DIV_LSB         = 9;
   localparam int MODE_CKS_BIT    = 15;
   localparam int MODE_ISRC_BIT   = 0;
   localparam int MODE_MASTER_BIT = 1;
   localparam int MODE_RUN_BIT    = 2;
   localparam int PRESC_F_W       = 4;
   localparam int STAT_FULL_BIT   = 0;
   localparam int STAT_BUSY_BIT   = 1;
   localparam int STAT_RXNEW_BIT  = 2;
   localparam int IRQ_END_BIT     = 0;
   localparam int IRQ_EMPTY_BIT   = 1;
   localparam int IRQ_OVR_BIT     = 2;

   // ****************************************************************
   // prescaler codes and reset values
   // ****************************************************************
   localparam logic [PRESC_F_W-1:0] PRESC_MAX_DIV = 4'hb;
   localparam logic [PRESC_F_W-1:0] PRESC_TIMER   = 4'hf;
   localparam logic [DATA_W-1:0]    MODE_RST      = 16'h0000;
   localparam logic [7:0]           PRESC_RST     = 8'h00;
   localparam logic [DIV_W-1:0]     DIV_RST       = 7'h00;
   localparam logic [IRQ_W-1:0]     MASK_RST      = 3'h0;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ssc_bus_req_s;

endpackage : ssc_pkg

// *** logic/ssc_channel.sv ***
// clocked serial channel: slave and master transfer, operation clock select, register port
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module ssc_channel #(
   parameter bit UNIT_IDX = 1'b0
) (
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_in,
   input  wire ssc_pkg::ssc_bus_req_s       bus_req_in,
   output logic [ssc_pkg::DATA_W-1:0]       rd_data_out,
   input  wire logic                        timer_ch2_irq_in,
   input  wire logic                        timer_ch3_irq_in,
   input  wire logic                        sclk_in,
   output logic                             sclk_out,
   output logic                             sclk_oe_n_out,
   input  wire logic                        sdi_in,
   output logic                             sdo_out,
   output logic                             irq_out
);

   // ****************************************************************
   // registers and state
   // ****************************************************************
   logic [ssc_pkg::DATA_W-1:0]   mode_reg;
   logic [7:0]                   presc_reg;
   logic [ssc_pkg::DIV_W-1:0]    div_reg;
   logic [7:0]                   tx_buf_reg;
   logic                         buffer_full_flag_reg;
   logic [7:0]                   rx_buf_reg;
   logic                         rx_new_reg;
   logic [ssc_pkg::IRQ_W-1:0]    irq_stat_reg;
   logic [ssc_pkg::IRQ_W-1:0]    irq_mask_reg;
   logic [ssc_pkg::PCNT_W-1:0]   pcnt_reg;
   logic [ssc_pkg::DIV_W-1:0]    baud_cnt_reg;
   logic                         active_reg;
   logic                         sclk_reg;
   logic [3:0]                   bit_cnt_reg;
   logic [7:0]                   tx_sh_reg;
   logic [6:0]                   rx_sh_reg;
   logic                         sdo_reg;
   logic                         sck_meta_reg;
   logic                         sck_sync_reg;
   logic                         sdi_meta_reg;
   logic                         sdi_sync_reg;
   logic                         sck_samp_reg;
   logic                         sck_prev_reg;
   logic [ssc_pkg::DATA_W-1:0]   rd_data_reg;
   logic                         irq_reg;

   // ****************************************************************
   // register decode
   // ****************************************************************
   // one write enable per writable register, plus a data read strobe; the master never strobes both at once
   wire wr_data = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_DATA);
   wire wr_mode = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_MODE);
   wire wr_presc = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_PRESC);
   wire wr_istat = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_IRQ_STAT);
   wire wr_imask = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_IRQ_MASK);
   wire rd_data = bus_req_in.rd && (bus_req_in.addr == ssc_pkg::ADDR_DATA);

   // mode fields
   wire run_bit    = mode_reg[ssc_pkg::MODE_RUN_BIT];
   wire master_bit = mode_reg[ssc_pkg::MODE_MASTER_BIT];
   wire isrc_bit   = mode_reg[ssc_pkg::MODE_ISRC_BIT];
   wire cks_bit    = mode_reg[ssc_pkg::MODE_CKS_BIT];

   // ****************************************************************
   // operation clock select
   // ****************************************************************
   // the timer tick comes from logic on this clock, so it needs no synchroniser
   wire timer_tick = UNIT_IDX ? timer_ch3_irq_in : timer_ch2_irq_in;

   logic [1:0] field_en;

   // one enable per prescaler field; the shared counter keeps both phase aligned
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_presc
         wire [ssc_pkg::PRESC_F_W-1:0] code = presc_reg[gi*ssc_pkg::PRESC_F_W +: ssc_pkg::PRESC_F_W];
         // code 11 wraps the shift to zero, so the mask becomes all ones
         wire [ssc_pkg::PCNT_W-1:0] mask =
            ssc_pkg::PCNT_W'(ssc_pkg::PCNT_W'(1) << code) - ssc_pkg::PCNT_W'(1);
         wire div_hit = ((pcnt_reg & mask) == mask);
         // prohibited codes give no clock at all rather than an odd rate
         assign field_en[gi] = (code <= ssc_pkg::PRESC_MAX_DIV) ? div_hit :
                               (code == ssc_pkg::PRESC_TIMER) ? timer_tick : 1'b0;
      end
   endgenerate

   wire mck_en = run_bit && field_en[cks_bit];

   // free running prescaler counter
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pcnt_reg <= '0;
      end else begin
         pcnt_reg <= pcnt_reg + ssc_pkg::PCNT_W'(1);
      end
   end

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // the second stage is the only reader of the first
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sck_meta_reg <= 1'b1;
         sck_sync_reg <= 1'b1;
         sdi_meta_reg <= 1'b0;
         sdi_sync_reg <= 1'b0;
      end else begin
         sck_meta_reg <= sclk_in;
         sck_sync_reg <= sck_meta_reg;
         sdi_meta_reg <= sdi_in;
         sdi_sync_reg <= sdi_meta_reg;
      end
   end

   // external clock sampled by the operation clock; this is what caps the slave rate
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sck_samp_reg <= 1'b1;
         sck_prev_reg <= 1'b1;
      end else if (mck_en) begin
         sck_samp_reg <= sck_sync_reg;
         sck_prev_reg <= sck_samp_reg;
      end
   end

   // ****************************************************************
   // transfer clock and edges
   // ****************************************************************
   // half period is div+1 operation clock pulses, so the full period doubles it
   wire half_tick = mck_en && (baud_cnt_reg == div_reg);
   wire m_fall = master_bit && active_reg && half_tick && sclk_reg;
   wire m_rise = master_bit && active_reg && half_tick && !sclk_reg;
   wire s_fall = !master_bit && mck_en && sck_prev_reg && !sck_samp_reg;
   wire s_rise = !master_bit && mck_en && !sck_prev_reg && sck_samp_reg;
   wire fall_ev = m_fall || s_fall;
   wire rise_ev = m_rise || s_rise;

   // a pending buffer word moves into the shifter at the leading edge of a word
   wire load_ev = fall_ev && (bit_cnt_reg == 4'h0) && buffer_full_flag_reg;
   wire word_end = rise_ev && (bit_cnt_reg == 4'(ssc_pkg::WORD_BITS - 1));
   wire [7:0] rx_word = {rx_sh_reg, sdi_sync_reg};

   // master starts on a pending word and idles with the clock high
   wire m_start = run_bit && master_bit && !active_reg && buffer_full_flag_reg;
   wire m_stop = word_end && master_bit && !buffer_full_flag_reg;

   // baud divider and master clock level
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         baud_cnt_reg <= ssc_pkg::DIV_RST;
         sclk_reg     <= 1'b1;
         active_reg   <= 1'b0;
      end else if (!run_bit || !master_bit) begin
         baud_cnt_reg <= ssc_pkg::DIV_RST;
         sclk_reg     <= 1'b1;
         active_reg   <= 1'b0;
      end else begin
         if (mck_en) begin
            baud_cnt_reg <= half_tick ? ssc_pkg::DIV_RST : baud_cnt_reg + ssc_pkg::DIV_W'(1);
         end
         if (m_fall || m_rise) begin
            sclk_reg <= !sclk_reg;
         end
         if (m_start) begin
            active_reg <= 1'b1;
         end else if (m_stop) begin
            active_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // shifter
   // ****************************************************************
   // with no pending word the slave sends zeros from the emptied shifter
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bit_cnt_reg <= 4'h0;
         tx_sh_reg   <= 8'h00;
         rx_sh_reg   <= 7'h00;
         sdo_reg     <= 1'b0;
      end else if (!run_bit) begin
         bit_cnt_reg <= 4'h0;
      end else begin
         if (fall_ev) begin
            sdo_reg   <= load_ev ? tx_buf_reg[7] : tx_sh_reg[7];
            tx_sh_reg <= load_ev ? {tx_buf_reg[6:0], 1'b0} : {tx_sh_reg[6:0], 1'b0};
         end
         if (rise_ev) begin
            rx_sh_reg   <= rx_word[6:0];
            bit_cnt_reg <= word_end ? 4'h0 : bit_cnt_reg + 4'h1;
         end
      end
   end

   // ****************************************************************
   // data buffers
   // ****************************************************************
   // a write in the load cycle wins, so the new word stays pending
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_buf_reg           <= 8'h00;
         div_reg              <= ssc_pkg::DIV_RST;
         buffer_full_flag_reg <= 1'b0;
      end else begin
         if (wr_data) begin
            tx_buf_reg <= bus_req_in.wdata[7:0];
            div_reg    <= bus_req_in.wdata[ssc_pkg::DIV_MSB:ssc_pkg::DIV_LSB];
         end
         if (wr_data) begin
            buffer_full_flag_reg <= 1'b1;
         end else if (load_ev) begin
            buffer_full_flag_reg <= 1'b0;
         end
      end
   end

   // received word; a pending-word read does not count as taking it
   wire rx_take = rd_data && !buffer_full_flag_reg;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_buf_reg <= 8'h00;
         rx_new_reg <= 1'b0;
      end else begin
         if (word_end) begin
            rx_buf_reg <= rx_word;
         end
         if (word_end) begin
            rx_new_reg <= 1'b1;
         end else if (rx_take) begin
            rx_new_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   // mode may change mid-transfer; the source bit is read at each event
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_reg     <= ssc_pkg::MODE_RST;
         presc_reg    <= ssc_pkg::PRESC_RST;
         irq_mask_reg <= ssc_pkg::MASK_RST;
      end else begin
         if (wr_mode) begin
            mode_reg <= bus_req_in.wdata;
         end
         if (wr_presc) begin
            presc_reg <= bus_req_in.wdata[7:0];
         end
         if (wr_imask) begin
            irq_mask_reg <= bus_req_in.wdata[ssc_pkg::IRQ_W-1:0];
         end
      end
   end

   // ****************************************************************
   // interrupts
   // ****************************************************************
   // the source bit picks end-of-word or buffer-empty events
   logic [ssc_pkg::IRQ_W-1:0] irq_set;
   logic [ssc_pkg::IRQ_W-1:0] irq_clr;
   logic [ssc_pkg::IRQ_W-1:0] irq_stat_next;

   assign irq_set[ssc_pkg::IRQ_END_BIT]   = word_end && !isrc_bit;
   assign irq_set[ssc_pkg::IRQ_EMPTY_BIT] = load_ev && isrc_bit;
   assign irq_set[ssc_pkg::IRQ_OVR_BIT]   = word_end && rx_new_reg && !rx_take;
   assign irq_clr = wr_istat ? bus_req_in.wdata[ssc_pkg::IRQ_W-1:0] : '0;
   // set beats a clear that lands in the same cycle
   assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat_reg <= '0;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg      <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   wire busy = active_reg || (bit_cnt_reg != 4'h0);
   // pending transmit word shows through while full, else the received word
   wire [7:0] data_low = buffer_full_flag_reg ? tx_buf_reg : rx_buf_reg;
   wire [ssc_pkg::DATA_W-1:0] stat_word = {13'h0000, rx_new_reg, busy, buffer_full_flag_reg};
   wire [ssc_pkg::DATA_W-1:0] rd_mux =
      (bus_req_in.addr == ssc_pkg::ADDR_DATA)     ? {div_reg, 1'b0, data_low} :
      (bus_req_in.addr == ssc_pkg::ADDR_MODE)     ? mode_reg :
      (bus_req_in.addr == ssc_pkg::ADDR_PRESC)    ? {8'h00, presc_reg} :
      (bus_req_in.addr == ssc_pkg::ADDR_STAT)     ? stat_word :
      (bus_req_in.addr == ssc_pkg::ADDR_IRQ_STAT) ? {13'h0000, irq_stat_reg} :
      (bus_req_in.addr == ssc_pkg::ADDR_IRQ_MASK) ? {13'h0000, irq_mask_reg} : 16'h0000;

   // read data stands one cycle only, zero otherwise
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_reg <= 16'h0000;
      end else begin
         rd_data_reg <= bus_req_in.rd ? rd_mux : 16'h0000;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // the clock pin is driven only in master role
   logic sclk_oe_n_reg;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_oe_n_reg <= 1'b1;
      end else begin
         sclk_oe_n_reg <= !(run_bit && master_bit);
      end
   end

   assign rd_data_out   = rd_data_reg;
   assign sclk_out      = sclk_reg;
   assign sclk_oe_n_out = sclk_oe_n_reg;
   assign sdo_out       = sdo_reg;
   assign irq_out       = irq_reg;

endmodule : ssc_channel

// *** bench/ssc_channel_properties.sv ***
// concurrent checks on the serial channel ports
`timescale 1ns/1ps
module ssc_channel_chk (
   input wire logic                        ref_clk_in,
   input wire logic                        rst_in,
   input wire ssc_pkg::ssc_bus_req_s       bus_req_in,
   input wire logic [ssc_pkg::DATA_W-1:0]  rd_data_out,
   input wire logic                        sclk_out,
   input wire logic                        sclk_oe_n_out,
   input wire logic                        sdo_out,
   input wire logic                        irq_out
);
   // ****************************************************************
   // request decode
   // ****************************************************************
   // named strobes keep the properties short
   wire logic wr_data = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_DATA);
   wire logic rd_data = bus_req_in.rd && (bus_req_in.addr == ssc_pkg::ADDR_DATA);
   wire logic rd_stat = bus_req_in.rd && (bus_req_in.addr == ssc_pkg::ADDR_STAT);
   wire logic wr_mask = bus_req_in.wr && (bus_req_in.addr == ssc_pkg::ADDR_IRQ_MASK);

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   // ****************************************************************
   // properties
   // ****************************************************************
   chk_read_idle_zero: assert property (
      !$past(bus_req_in.rd) |-> rd_data_out == 16'h0000) else $error("read data outside answer cycle");
   chk_release_values: assert property (
      $fell(rst_in) |-> sclk_out && sclk_oe_n_out && !irq_out && !sdo_out) else $error("bad values after reset");
   chk_idle_clock_high: assert property (
      sclk_oe_n_out |-> sclk_out) else $error("serial clock not high while undriven");
   chk_clock_driven: assert property (
      $fell(sclk_out) |-> !sclk_oe_n_out) else $error("serial clock toggled while undriven");
   chk_full_on_write: assert property (
      wr_data ##1 rd_stat |=> rd_data_out[ssc_pkg::STAT_FULL_BIT]) else $error("full flag not set by write");
   chk_tx_readback: assert property (
      wr_data ##1 rd_data |=> rd_data_out[7:0] == $past(bus_req_in.wdata[7:0], 2))
      else $error("pending word not read back");
   chk_div_readback: assert property (
      wr_data ##1 rd_data |=> rd_data_out[15:9] == $past(bus_req_in.wdata[15:9], 2))
      else $error("divisor field not read back");
   chk_mask_off_quiet: assert property (
      (wr_mask && bus_req_in.wdata[2:0] == 3'h0) ##1 !wr_mask |-> ##1 !irq_out)
      else $error("interrupt high with mask cleared");
endmodule : ssc_channel_chk

bind ssc_channel ssc_channel_chk ssc_channel_chk_inst (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus_req_in(bus_req_in), .rd_data_out(rd_data_out),
   .sclk_out(sclk_out), .sclk_oe_n_out(sclk_oe_n_out), .sdo_out(sdo_out), .irq_out(irq_out));

// *** bench/ssc_far_master.sv ***
// behavioural external serial master that clocks the slave channel
`timescale 1ns/1ps
module ssc_far_master #(
   parameter int HALF = 6
) (
   input  wire logic       clk_in,
   input  wire logic       go_in,
   input  wire logic [7:0] tx_in,
   input  wire logic       sdo_in,
   output logic            sclk_out,
   output logic            sdi_out,
   output logic [7:0]      rx_out,
   output logic            done_out
);
   // ****************************************************************
   // frame engine
   // ****************************************************************
   // six clocks a half keeps the link well under the opclk/6 sampling limit
   initial begin
      sclk_out = 1'b1;
      sdi_out  = 1'b0;
      rx_out   = 8'h00;
      done_out = 1'b0;
      forever begin
         // between frames the clock stands high and data wanders, so stale bits never look valid
         while (!go_in) begin
            @(posedge clk_in);
            sdi_out <= ~sdi_out;
         end
         done_out <= 1'b0;
         for (int i = 7; i >= 0; i--) begin
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b0;
            sdi_out  <= tx_in[i]; // msb first
            repeat (HALF) @(posedge clk_in);
            sclk_out  <= 1'b1;
            rx_out[i] <= sdo_in;
         end
         repeat (HALF) @(posedge clk_in); // last bit held while the slave samples it
         done_out <= 1'b1;
      end
   end
endmodule : ssc_far_master

// *** bench/tb_top.sv ***
// self-checking bench for the serial channel
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   typedef struct packed {
      logic [7:0] presc;
      logic       cks;
      logic [6:0] div;
      int         per;
   } ssc_row_s;
   logic                  ref_clk_in, rst_in, sclk_m, sclk_s, oe_n, sdi, sdo, irq, m_go, m_done;
   ssc_pkg::ssc_bus_req_s req;
   logic [15:0]           rd_data;
   logic [7:0]            m_tx, m_rx;
   logic [3:0]            t2c = 4'h0;
   logic [3:0]            t3c = 4'h0;
   int                    n_fail = 0;
   int                    check_count = 0;
   int                    cyc_n = 0;
   // prescaler, select, divisor and the period they give; all codes legal but the last, a no-clock probe
   ssc_row_s rows [7] = '{'{8'h10, 1'b0, 7'h00, 2}, '{8'h21, 1'b0, 7'h00, 4}, '{8'h10, 1'b0, 7'h02, 6},
      '{8'h30, 1'b1, 7'h01, 32}, '{8'h1b, 1'b0, 7'h00, 4096}, '{8'h1f, 1'b0, 7'h01, 20}, '{8'h1c, 1'b0, 7'h00, 0}};

   ssc_channel #(.UNIT_IDX(1'b0)) ssc_channel_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .bus_req_in(req), .rd_data_out(rd_data), .timer_ch2_irq_in(t2c == 4'h0), .timer_ch3_irq_in(t3c == 4'h0),
      .sclk_in(sclk_s), .sclk_out(sclk_m), .sclk_oe_n_out(oe_n), .sdi_in(sdi), .sdo_out(sdo), .irq_out(irq));
   ssc_far_master ssc_far_master_inst (.clk_in(ref_clk_in), .go_in(m_go), .tx_in(m_tx), .sdo_in(sdo),
      .sclk_out(sclk_s), .sdi_out(sdi), .rx_out(m_rx), .done_out(m_done));

   // ****************************************************************
   // clock, ticks and timeout
   // ****************************************************************
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   // ch3 ticks at another rate so a wrong tick choice shows in the period
   always @(posedge ref_clk_in) begin
      t2c <= (t2c == 4'h4) ? 4'h0 : t2c + 4'h1;
      t3c <= (t3c == 4'h6) ? 4'h0 : t3c + 4'h1;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         n_fail++;
         conclude();
      end
   end

   // ****************************************************************
   // bus and link tasks
   // ****************************************************************
   task automatic conclude();
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   // one bus cycle; every task returns just after an edge so inputs never race it
   task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
      @(posedge ref_clk_in);
      #1;
   endtask : cyc
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      cyc(1'b1, 1'b0, a, d);
      cyc(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [15:0] v);
      cyc(1'b0, 1'b1, a, 16'h0000);
      v = rd_data;
      cyc(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask : rreg
   task automatic frame(input logic [7:0] b);
      m_tx <= b;
      m_go <= 1'b1;
      @(posedge ref_clk_in);
      #1;
      m_go <= 1'b0;
      for (int t = 0; t < 400 && !m_done; t++) begin
         @(posedge ref_clk_in);
         #1;
      end
      `CHK("frame end", 1'b1, m_done)
   endtask : frame
   // cycles between two falls of the master clock, zero if it never runs
   task automatic period(output int p);
      int f1;
      logic prev;
      p = 0;
      f1 = -1;
      prev = sclk_m;
      for (int t = 0; t < 9000 && p == 0; t++) begin
         @(posedge ref_clk_in);
         #1;
         if (prev && !sclk_m) begin
            if (f1 < 0) f1 = t;
            else p = t - f1;
         end
         prev = sclk_m;
      end
   endtask : period

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [15:0] v;
      int          p;
      rst_in = 1'b1;
      req = '0;
      m_go = 1'b0;
      m_tx = 8'h00;
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      // release stands in for the unit enable, so software lets four clocks pass first
      repeat (4) @(posedge ref_clk_in);
      #1;
      // master clock rate over prescaler codes, both fields, timer tick and a prohibited code
      foreach (rows[i]) begin
         wreg(ssc_pkg::ADDR_PRESC, {8'h00, rows[i].presc});
         wreg(ssc_pkg::ADDR_MODE, {rows[i].cks, 12'h000, 3'b110});
         wreg(ssc_pkg::ADDR_DATA, {rows[i].div, 1'b0, 8'hc3});
         period(p);
         `CHK("period", rows[i].per, p)
         `CHK("drive", 1'b0, oe_n)
         wreg(ssc_pkg::ADDR_MODE, 16'h0000); // channel stopped before its clocking changes
      end
      // reset with the channel stopped, then reset values and an unmapped address
      rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      `CHK("rst outs", 4'hc, {sclk_m, oe_n, irq, sdo})
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      rreg(ssc_pkg::ADDR_MODE, v);
      `CHK("mode rst", ssc_pkg::MODE_RST, v)
      rreg(ssc_pkg::ADDR_PRESC, v);
      `CHK("presc rst", {8'h00, ssc_pkg::PRESC_RST}, v)
      wreg(4'hf, 16'hffff);
      rreg(4'hf, v);
      `CHK("unmapped", 16'h0000, v)
      // slave continuous mode, buffer empty interrupt, overwrite while full
      wreg(ssc_pkg::ADDR_MODE, 16'h0005);
      wreg(ssc_pkg::ADDR_IRQ_MASK, 16'h0002);
      cyc(1'b1, 1'b0, ssc_pkg::ADDR_DATA, 16'h00a5);
      cyc(1'b1, 1'b0, ssc_pkg::ADDR_DATA, 16'h003c);
      rreg(ssc_pkg::ADDR_DATA, v);
      `CHK("overwrite", 16'h003c, v)
      fork
         frame(8'h96);
         begin
            repeat (40) @(posedge ref_clk_in);
            #1;
            cyc(1'b1, 1'b0, ssc_pkg::ADDR_DATA, 16'h005a);
            rreg(ssc_pkg::ADDR_STAT, v);
            `CHK("full", 1'b1, v[ssc_pkg::STAT_FULL_BIT])
            rreg(ssc_pkg::ADDR_DATA, v);
            `CHK("pending", 16'h005a, v)
         end
      join
      `CHK("word1", 8'h3c, m_rx)
      `CHK("irq empty", 1'b1, irq)
      rreg(ssc_pkg::ADDR_IRQ_STAT, v);
      `CHK("irq stat1", 16'h0002, v)
      wreg(ssc_pkg::ADDR_IRQ_STAT, 16'h0002);
      `CHK("irq clr", 1'b0, irq)
      wreg(ssc_pkg::ADDR_IRQ_MASK, 16'h0000);
      wreg(ssc_pkg::ADDR_MODE, 16'h0004); // source switched before the first bit
      frame(8'h69);
      `CHK("word2", 8'h5a, m_rx)
      `CHK("masked", 1'b0, irq)
      rreg(ssc_pkg::ADDR_IRQ_STAT, v);
      `CHK("irq stat2", 16'h0005, v)
      rreg(ssc_pkg::ADDR_STAT, v);
      `CHK("empty", 1'b0, v[ssc_pkg::STAT_FULL_BIT])
      rreg(ssc_pkg::ADDR_DATA, v);
      `CHK("rx", 16'h0069, v)
      wreg(ssc_pkg::ADDR_IRQ_MASK, 16'h0001);
      `CHK("unmask", 1'b1, irq)
      wreg(ssc_pkg::ADDR_IRQ_MASK, 16'h0000);
      `CHK("remask", 1'b0, irq)
      conclude();
   end
endmodule : tb_top
